// ==== design/usl_line_status.sv ====
// How it works
// - error bit set while any queued char bad
// - transmitter empty needs holding and shifter empty
// - fifo mode: fifo and shifter empty
// - holding empty set on move, cleared on load
// - holding empty with enable raises interrupt
// - break flag on full low frame, read clears
// - one break char per break condition
// - framing flag on low stop, read clears
// - after framing error resync on low level
// - framing report time depends on fifo enable
// - fifo mode errors follow head character
// - parity flag on mismatch, read clears
// - non-fifo overrun overwrites the receive buffer
// - fifo overrun when full, drop incoming char
// - data ready while unread characters held
// - status bits above seven read zero
// - parity odd at zero, even at one
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module usl_line_status
    import usl_pkg::*;
#(
    parameter int RX_DEPTH = 16,
    parameter int TX_DEPTH = 16
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [USL_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [USL_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic baud_tick16,
    input wire logic rx_line,
    output logic tx_line,
    output logic irq
);

    localparam int RPW = $clog2(RX_DEPTH);
    localparam int TPW = $clog2(TX_DEPTH);
    localparam logic [RPW:0] RX_CAP = (RPW+1)'(RX_DEPTH);
    localparam logic [TPW:0] TX_CAP = (TPW+1)'(TX_DEPTH);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic aw_full, w_full;
    logic [USL_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] irq_stat, irq_mask;
    logic [31:0] rd_mux;
    logic rd_hit;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire do_write = aw_full && w_full && !s_axi_bvalid;
    wire [7:0] wa = {aw_addr[7:2], 2'b00};
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire wr_data = do_write && wa == USL_OFS_DATA && w_strb[0];
    wire wr_ctrl = do_write && wa == USL_OFS_CTRL && w_strb[0];
    wire wr_istat = do_write && wa == USL_OFS_IRQ_STAT && w_strb[0];
    wire wr_imask = do_write && wa == USL_OFS_IRQ_MASK && w_strb[0];
    wire wr_hit = wa <= USL_OFS_IRQ_MASK;
    wire lsr_read = ar_fire && ra == USL_OFS_STATUS;
    wire fifo_en = ctrl[CTRL_FIFO_EN];
    wire par_en = ctrl[CTRL_PAR_EN];
    wire par_sel = ctrl[CTRL_PAR_SEL];
    // switching modes flushes both queues so stale depth never leaks across
    wire flush = wr_ctrl && w_data[CTRL_FIFO_EN] != fifo_en;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready = !w_full;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (aw_fire)
            begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_fire)
            begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ar_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ----------------------------------------------------------------
    // receive pin synchroniser and framer
    // ----------------------------------------------------------------
    logic rx_meta, rx_s;
    usl_rx_state_t rx_st;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;

    wire rx_at_end = baud_tick16 && rx_tick == TICK_LAST;
    wire rx_done = rx_st == RX_STOP && rx_at_end;
    wire par_bad = par_en && (rx_par != (par_sel ? ^rx_sh : ~^rx_sh));
    wire is_break = !rx_s && rx_sh == 8'h00 && (!par_en || !rx_par);
    // low stop bit: a framing error unless the whole frame was low (break)
    wire [10:0] rx_word = {is_break, !rx_s && !is_break, par_bad && !is_break, rx_sh};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {rx_s, rx_meta} <= 2'b11;
        else
            {rx_s, rx_meta} <= {rx_meta, rx_line};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_st <= RX_IDLE;
            rx_tick <= 4'h0;
            rx_bit <= 3'h0;
            rx_sh <= 8'h00;
            rx_par <= 1'b0;
        end
        else
        begin
            if (baud_tick16)
                rx_tick <= rx_tick + 4'h1;
            case (rx_st)
                RX_IDLE:
                    if (!rx_s)
                    begin
                        rx_st <= RX_START;
                        rx_tick <= 4'h0;
                    end
                RX_START:
                    if (baud_tick16 && rx_tick == TICK_MID)
                    begin
                        rx_st <= rx_s ? RX_IDLE : RX_DATA;
                        rx_tick <= 4'h0;
                        rx_bit <= 3'h0;
                    end
                RX_DATA:
                    if (rx_at_end)
                    begin
                        rx_sh <= {rx_s, rx_sh[7:1]};
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == DATA_LAST)
                            rx_st <= par_en ? RX_PAR : RX_STOP;
                    end
                RX_PAR:
                    if (rx_at_end)
                    begin
                        rx_par <= rx_s;
                        rx_st <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_at_end)
                    begin
                        if (rx_s)
                            rx_st <= RX_IDLE;
                        else if (is_break)
                            rx_st <= RX_BREAK;
                        else
                        begin
                            // the low stop bit is taken as the next start bit
                            rx_st <= RX_DATA;
                            rx_bit <= 3'h0;
                        end
                    end
                RX_BREAK:
                    // hold here until the line idles: one break char however long it lasts
                    if (rx_s)
                        rx_st <= RX_IDLE;
                default:
                    rx_st <= RX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // receive queue (depth one in non-fifo mode)
    // ----------------------------------------------------------------
    logic [10:0] rx_mem [RX_DEPTH];
    logic [RPW-1:0] rx_rd, rx_wr;
    logic [RPW:0] rx_cnt;
    logic [RX_DEPTH-1:0] rx_bad;

    wire rx_empty = rx_cnt == '0;
    wire rx_full = fifo_en ? rx_cnt == RX_CAP : !rx_empty;
    wire rx_pop = ar_fire && ra == USL_OFS_DATA && !rx_empty;
    wire rx_over = rx_done && rx_full && !rx_pop;
    wire rx_push = rx_done && !rx_over;
    wire rx_overwrite = rx_over && !fifo_en;
    wire [RPW-1:0] rx_rd_nxt = rx_rd + RPW'(1);
    wire [RPW-1:0] rx_widx = rx_overwrite ? rx_rd : rx_wr;
    wire [10:0] rx_head = rx_mem[rx_rd];
    // fifo mode: errors show when a char reaches the head
    wire head_load = fifo_en && ((rx_empty && rx_push) || (rx_pop && rx_cnt == (RPW+1)'(1) && rx_push)
                     || (rx_pop && rx_cnt > (RPW+1)'(1)));
    wire [10:0] head_word = rx_pop && rx_cnt > (RPW+1)'(1) ? rx_mem[rx_rd_nxt] : rx_word;
    wire [2:0] err_set = fifo_en ? (head_load ? head_word[10:8] : 3'h0)
                                 : (rx_done ? rx_word[10:8] : 3'h0);
    wire [RPW:0] next_rx_cnt = rx_cnt + (RPW+1)'(rx_push && !rx_overwrite) - (RPW+1)'(rx_pop);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || flush)
        begin
            rx_rd <= '0;
            rx_wr <= '0;
            rx_cnt <= '0;
        end
        else
        begin
            rx_cnt <= next_rx_cnt;
            if (rx_pop)
                rx_rd <= rx_rd_nxt;
            if (rx_push && !rx_overwrite)
                rx_wr <= rx_wr + RPW'(1);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (rx_push || rx_overwrite)
            rx_mem[rx_widx] <= rx_word;
    end

    genvar gi;
    generate
        for (gi = 0; gi < RX_DEPTH; gi++)
        begin : g_rx_bad
            wire [RPW-1:0] offs = RPW'(gi) - rx_rd;
            assign rx_bad[gi] = {1'b0, offs} < rx_cnt && |rx_mem[gi][10:8];
        end
    endgenerate

    // ----------------------------------------------------------------
    // transmit queue and shifter
    // ----------------------------------------------------------------
    logic [7:0] tx_mem [TX_DEPTH];
    logic [TPW-1:0] tx_rd, tx_wr;
    logic [TPW:0] tx_cnt;
    logic [10:0] tx_frame;
    logic [3:0] tx_left, tx_tick;

    wire tx_empty = tx_cnt == '0;
    // a write into a full holding stage is dropped
    wire tx_push = wr_data && !(fifo_en ? tx_cnt == TX_CAP : !tx_empty);
    wire tx_load = tx_left == 4'h0 && !tx_empty;
    wire [7:0] tx_byte = tx_mem[tx_rd];
    wire tx_pbit = par_en ? (par_sel ? ^tx_byte : ~^tx_byte) : 1'b1;
    wire [TPW:0] next_tx_cnt = tx_cnt + (TPW+1)'(tx_push) - (TPW+1)'(tx_load);
    wire hold_empty = tx_empty;
    wire tx_idle = tx_empty && tx_left == 4'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || flush)
        begin
            tx_rd <= '0;
            tx_wr <= '0;
            tx_cnt <= '0;
        end
        else
        begin
            tx_cnt <= next_tx_cnt;
            if (tx_load)
                tx_rd <= tx_rd + TPW'(1);
            if (tx_push)
                tx_wr <= tx_wr + TPW'(1);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (tx_push)
            tx_mem[tx_wr] <= w_data[7:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_frame <= 11'h7ff;
            tx_left <= 4'h0;
            tx_tick <= 4'h0;
        end
        else if (tx_load)
        begin
            tx_frame <= {1'b1, tx_pbit, tx_byte, 1'b0};
            tx_left <= par_en ? TX_BITS_PAR : TX_BITS_NOPAR;
            tx_tick <= 4'h0;
        end
        else if (tx_left != 4'h0 && baud_tick16)
        begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == TICK_LAST)
            begin
                tx_frame <= {1'b1, tx_frame[10:1]};
                tx_left <= tx_left - 4'h1;
            end
        end
    end

    assign tx_line = tx_frame[0];

    // ----------------------------------------------------------------
    // line status flags, control and interrupts
    // ----------------------------------------------------------------
    logic [4:1] lsr_err;

    wire [4:1] err_new = {err_set, rx_over};
    wire [ST_W-1:0] lsr = {|rx_bad, tx_idle, hold_empty, lsr_err, !rx_empty};
    wire [IRQ_W-1:0] irq_set = {rx_push, |err_new, hold_empty};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            lsr_err <= 4'h0;
        else
            lsr_err <= (lsr_err & ~{4{lsr_read}}) | err_new;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= CTRL_RESET;
            irq_mask <= IRQ_RESET;
            irq_stat <= IRQ_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= w_data[CTRL_W-1:0];
            if (wr_imask)
                irq_mask <= w_data[IRQ_W-1:0];
            // a fresh event beats a same-cycle clear
            irq_stat <= (irq_stat & ~(wr_istat ? w_data[IRQ_W-1:0] : IRQ_RESET)) | irq_set;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    assign rd_hit = ra <= USL_OFS_IRQ_MASK;
    assign rd_mux = ra == USL_OFS_DATA ? {24'h0, rx_empty ? 8'h00 : rx_head[7:0]}
                  : ra == USL_OFS_STATUS ? {24'h0, lsr}
                  : ra == USL_OFS_CTRL ? {29'h0, ctrl}
                  : ra == USL_OFS_IRQ_STAT ? {29'h0, irq_stat}
                  : ra == USL_OFS_IRQ_MASK ? {29'h0, irq_mask}
                  : 32'h0;

endmodule : usl_line_status

`default_nettype wire

// ==== design/usl_pkg.sv ====
package usl_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int USL_ADDR_W = 8;
    localparam logic [7:0] USL_OFS_DATA = 8'h00;
    localparam logic [7:0] USL_OFS_STATUS = 8'h04;
    localparam logic [7:0] USL_OFS_CTRL = 8'h08;
    localparam logic [7:0] USL_OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] USL_OFS_IRQ_MASK = 8'h10;

    // ----------------------------------------------------------------
    // line status bit positions
    // ----------------------------------------------------------------
    localparam int ST_RDY = 0;
    localparam int ST_OVR = 1;
    localparam int ST_PAR = 2;
    localparam int ST_FRM = 3;
    localparam int ST_BRK = 4;
    localparam int ST_HOLD = 5;
    localparam int ST_IDLE = 6;
    localparam int ST_RXERR = 7;
    localparam int ST_W = 8;

    // ----------------------------------------------------------------
    // control register fields and reset value
    // ----------------------------------------------------------------
    localparam int CTRL_FIFO_EN = 0;
    localparam int CTRL_PAR_EN = 1;
    localparam int CTRL_PAR_SEL = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // ----------------------------------------------------------------
    // interrupt status / mask fields
    // ----------------------------------------------------------------
    localparam int IRQ_TX_HOLDING_EMPTY_FLAG = 0;
    localparam int IRQ_LINE = 1;
    localparam int IRQ_RX = 2;
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // ----------------------------------------------------------------
    // character timing, in oversample ticks and in bits
    // ----------------------------------------------------------------
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [2:0] DATA_LAST = 3'h7;
    localparam logic [3:0] TX_BITS_PAR = 4'hb;
    localparam logic [3:0] TX_BITS_NOPAR = 4'ha;

    // ----------------------------------------------------------------
    // bus answers
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BREAK} usl_rx_state_t;

endpackage : usl_pkg

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
    import usl_pkg::*;
    logic aclk, aresetn, baud_tick16, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, d, e;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [31:0] s_axi_wdata, rd;
    logic [1:0] rs;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_line, rx_line, irq;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    int num_errors, compares;
    logic [7:0] q[$];
    logic ovr, fifo;

    usl_line_status #(.RX_DEPTH(4), .TX_DEPTH(4)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .baud_tick16, .rx_line, .tx_line, .irq);
    usl_peer #(.BITC(32)) peer (.aclk, .tx_line, .rx_line);

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // one tick every second cycle, so a bit lasts 32 cycles
    always @(posedge aclk) baud_tick16 <= ~baud_tick16;

    task automatic stop_test;
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        compares++;
        if (g !== x)
        begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk

    // ------------------------------------------------------------
    // bus master
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, tw, tr, done;
        int n;
        done = 1'b0;
        n = 0;
        @(posedge aclk);
        if (w)
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end
        else
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        while (!done)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            done = w ? s_axi_bvalid : s_axi_rvalid;
            rd = s_axi_rdata;
            rs = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            if (tr)
                s_axi_arvalid <= 1'b0;
            n++;
            if (n > 50)
            begin
                num_errors++;
                stop_test();
            end
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        chk({30'h0, rs}, {30'h0, er}, "bus answer");
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0, RESP_OKAY);
        chk(rd, x, "read value");
    endtask : rdchk

    // ------------------------------------------------------------
    // receive model
    // ------------------------------------------------------------
    task automatic rx(input logic [7:0] c, input int par, input logic stop);
        peer.send(c, par, stop);
        if (q.size() < (fifo ? 4 : 1))
            q.push_back(c);
        else
        begin
            ovr = 1'b1;
            if (!fifo)
                q[0] = c;
        end
    endtask : rx

    task automatic st(input logic [31:0] x);
        rdchk(USL_OFS_STATUS, 32'h60 | x | {30'h0, ovr, q.size() != 0});
        ovr = 1'b0;
    endtask : st

    task automatic dat;
        rdchk(USL_OFS_DATA, (q.size() != 0) ? {24'h0, q.pop_front()} : 32'h0);
    endtask : dat

    task automatic irq_is(input logic v);
        @(negedge aclk);
        chk({31'h0, irq}, {31'h0, v}, "irq level");
    endtask : irq_is

    initial
    begin
        {aresetn, baud_tick16, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {num_errors, compares, ovr, fifo} = '0;
        void'($urandom(32'h205d));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        st(32'h0);
        rdchk(USL_OFS_CTRL, 32'h0);
        rdchk(USL_OFS_IRQ_MASK, 32'h0);
        bus(1'b0, 8'h14, 32'h0, RESP_SLVERR);
        bus(1'b1, 8'h14, 32'hff, RESP_SLVERR);
        irq_is(1'b0);
        d = 8'($urandom);
        rx(d, -1, 1'b1);
        st(32'h0);
        dat();
        st(32'h0);
        bus(1'b1, USL_OFS_IRQ_MASK, 32'h4, RESP_OKAY);
        irq_is(1'b1);
        bus(1'b1, USL_OFS_IRQ_STAT, 32'h4, RESP_OKAY);
        irq_is(1'b0);
        bus(1'b1, USL_OFS_IRQ_MASK, 32'h1, RESP_OKAY);
        irq_is(1'b1);
        bus(1'b1, USL_OFS_IRQ_MASK, 32'h0, RESP_OKAY);
        irq_is(1'b0);
        d = 8'($urandom);
        e = 8'($urandom);
        rx(d, -1, 1'b1);
        rx(e, -1, 1'b1);
        st(32'h0);
        dat();
        for (int ps = 0; ps < 2; ps++)
            for (int bad = 0; bad < 2; bad++)
            begin
                bus(1'b1, USL_OFS_CTRL, {29'h0, ps[0], 2'h2}, RESP_OKAY);
                d = 8'($urandom);
                rx(d, int'((ps[0] ? ^d : ~^d) ^ bad[0]), 1'b1);
                st(bad ? 32'h84 : 32'h0);
                dat();
            end
        bus(1'b1, USL_OFS_CTRL, 32'h0, RESP_OKAY);
        // low stop resyncs: an all-ones char follows
        rx(8'($urandom) | 8'h01, -1, 1'b0);
        repeat (12 * 32) @(posedge aclk);
        q[0] = 8'hff;
        ovr = 1'b1;
        st(32'h08);
        dat();
        bus(1'b1, USL_OFS_CTRL, 32'h1, RESP_OKAY);
        fifo = 1'b1;
        peer.brk(30);
        q.push_back(8'h0);
        st(32'h90);
        dat();
        st(32'h0);
        for (int i = 0; i < 5; i++)
            rx(8'($urandom), -1, 1'b1);
        st(32'h0);
        repeat (4) dat();
        st(32'h0);
        bus(1'b1, USL_OFS_CTRL, 32'h0, RESP_OKAY);
        d = 8'($urandom);
        bus(1'b1, USL_OFS_DATA, {24'h0, d}, RESP_OKAY);
        rdchk(USL_OFS_STATUS, 32'h20);
        repeat (12 * 32) @(posedge aclk);
        bus(1'b1, USL_OFS_CTRL, 32'h1, RESP_OKAY);
        e = 8'($urandom);
        bus(1'b1, USL_OFS_DATA, {24'h0, e}, RESP_OKAY);
        bus(1'b1, USL_OFS_DATA, 32'h5a, RESP_OKAY);
        rdchk(USL_OFS_STATUS, 32'h0);
        repeat (24 * 32) @(posedge aclk);
        rdchk(USL_OFS_STATUS, 32'h60);
        chk(32'(peer.got_q.size()), 32'h3, "tx count");
        chk({d, e, 8'h5a}, {peer.got_q[0], peer.got_q[1], peer.got_q[2]}, "tx data");
        stop_test();
    end

    initial
    begin
        repeat (40000) @(posedge aclk);
        num_errors++;
        stop_test();
    end
endmodule : tb

`default_nettype wire

// ==== sim/usl_line_status_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module usl_line_status_monitor
    import usl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [USL_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    // ------------------------------------------------------------
    // address of the read in flight
    // ------------------------------------------------------------
    logic [USL_ADDR_W-1:0] rd_addr;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rd_addr <= '0;
        else if (s_axi_arvalid && s_axi_arready)
            rd_addr <= s_axi_araddr;
    end
    wire logic rd_stat = rd_addr == USL_OFS_STATUS;
    wire logic rd_bad = (rd_addr > USL_OFS_IRQ_MASK) || (rd_addr[1:0] != 2'h0);

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_reset; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && s_axi_arready; endproperty
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer not held");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer not held");
    property p_arref; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arref: assert property (p_arref) else $error("read taken while answer pending");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_wans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wans: assert property (p_wans) else $error("write answer late");
    property p_hi; s_axi_rvalid && rd_stat |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("status upper bits not zero");
    property p_temt; s_axi_rvalid && rd_stat && s_axi_rdata[ST_IDLE] |-> s_axi_rdata[ST_HOLD]; endproperty
    a_temt: assert property (p_temt) else $error("empty flag with holding full");
    property p_bad; s_axi_rvalid && rd_bad |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
    a_bad: assert property (p_bad) else $error("unmapped read not refused");
    property p_ok; s_axi_rvalid && !rd_bad |-> s_axi_rresp == RESP_OKAY; endproperty
    a_ok: assert property (p_ok) else $error("mapped read refused");
endmodule : usl_line_status_monitor

bind usl_line_status usl_line_status_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

`default_nettype wire

// ==== sim/usl_peer.sv ====
`timescale 1ns/1ps
`default_nettype none

module usl_peer #(
    parameter int BITC = 32
)(
    input wire logic aclk,
    input wire logic tx_line,
    output logic rx_line
);
    logic [7:0] got_q[$];
    logic [7:0] cap;
    initial rx_line = 1'b1;

    task automatic bit_out(input logic v);
        @(posedge aclk);
        rx_line <= v;
        repeat (BITC - 1) @(posedge aclk);
    endtask : bit_out

    // par below zero sends no parity bit; line always ends high
    task automatic send(input logic [7:0] d, input int par, input logic stop);
        bit_out(1'b0);
        for (int i = 0; i < 8; i++)
            bit_out(d[i]);
        if (par >= 0)
            bit_out(par[0]);
        bit_out(stop);
        bit_out(1'b1);
    endtask : send

    task automatic brk(input int nbits);
        bit_out(1'b0);
        repeat (nbits * BITC) @(posedge aclk);
        bit_out(1'b1);
    endtask : brk

    // ------------------------------------------------------------
    // capture of transmitted characters, sampled mid bit
    // ------------------------------------------------------------
    always
    begin
        @(negedge tx_line);
        repeat (BITC / 2) @(negedge aclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BITC) @(negedge aclk);
            cap[i] = tx_line;
        end
        got_q.push_back(cap);
        repeat (BITC) @(negedge aclk);
    end
endmodule : usl_peer

`default_nettype wire
